// ---- src/spfp_pkg.sv ----
// package of constants for the synchronous parallel fifo port
package spfp_pkg;
    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W     = 8;   // parallel data bus width
    localparam int unsigned RX_DEPTH   = 8;   // receive buffer words
    localparam int unsigned TX_DEPTH   = 8;   // transmit buffer words
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ  = 50;  // i_mclk rate
    localparam int unsigned IFCLK_MHZ     = 60;  // documented interface clock
    // interface clock is derived by halving i_mclk; 60 MHz cannot be made from 50 MHz
    localparam int unsigned IFCLK_DIV_HALF = 1;  // mclk cycles per half period
    localparam int unsigned OE_LEAD_NS    = 20;  // least oe lead before read, one period
    localparam int unsigned OE_LEAD_CYC   =
        (OE_LEAD_NS * CORE_CLK_MHZ + 999) / 1000; // rounded up, at least one
    // ------------------------------------------------------------
    // wake / send-now state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPFP_WK_IDLE   = 3'b001,   // waiting for a strobe
        SPFP_WK_LOW    = 3'b010,   // strobe seen low, waiting for release
        SPFP_WK_ACT    = 3'b100    // emit at most one action pulse
    } spfp_wake_t;
    // reset values
    localparam logic RST_FLAG_N = 1'b1;  // flags read as "not ready" in reset
endpackage

// ---- src/spfp_fifo.sv ----
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module spfp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    output logic [WIDTH-1:0]      o_rd_data,
    output logic                  o_rd_valid,
    output logic [WIDTH-1:0]      o_peek_data,
    output logic [$clog2(DEPTH):0] o_count,
    input  wire logic             i_rd_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];     // storage array
    logic [AW-1:0]    wr_ptr;          // write index
    logic [AW-1:0]    rd_ptr;          // read index
    logic [AW:0]      count;           // words held
    logic             do_wr;
    logic             do_rd;
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = o_rd_valid && i_rd_ready;
    assign o_wr_ready = (count != (AW+1)'(DEPTH));
    assign o_rd_valid = (count != '0);
    assign o_rd_data  = mem[rd_ptr];
    // entry behind the head, so a reader can show it in the same edge as a pop
    assign o_peek_data = mem[AW'(rd_ptr + 1'b1)];
    assign o_count     = count;  // occupancy for flag logic outside
    // ------------------------------------------------------------
    // storage write
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end
    // ------------------------------------------------------------
    // pointers and occupancy
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            // pointers wrap naturally; depth is a power of two
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // spfp_fifo

// ---- src/spfp_port.sv ----
// synchronous parallel fifo port, device side
//
// Summary of operation
// R1: transfers happen on rising interface clock edge
// R2: device drives interface clock; partner stays synchronous
// R3: data bus driven only while oe low
// R4: rx flag low means data readable
// R5: byte read whenever rx flag, read low
// R6: partner lowers oe a clock before read
// R7: tx flag low means space available
// R8: byte written whenever tx flag, write low
// R9: read low presents byte, advances each clock
// R10: write low stores each clock, stops released
// R11: read strobe places head byte on bus
// R12: suspended, wake enabled: strobe requests resume
// R13: active: strobe flushes buffered data on next request
// R14: mode entry needs configuration and software command
// R15: strobes ignored while flag says not ready
`timescale 1ns/1ps
module spfp_port (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset,
    // parallel pins
    output logic                             o_interface_clock_out,
    input  wire logic [spfp_pkg::DATA_W-1:0] i_fifo_data_bus,
    output logic [spfp_pkg::DATA_W-1:0]      o_fifo_data_bus,
    output logic                             o_fifo_data_bus_oe,
    output logic                             o_rx_data_avail_n,
    output logic                             o_tx_space_avail_n,
    input  wire logic                        i_rd_n,
    input  wire logic                        i_wr_n,
    input  wire logic                        i_oe_n,
    input  wire logic                        i_send_now_wakeup_n,
    output logic                             o_usb_active_n,
    // usb core side
    input  wire logic [spfp_pkg::DATA_W-1:0] i_rx_data,
    input  wire logic                        i_rx_valid,
    output logic                             o_rx_ready,
    output logic [spfp_pkg::DATA_W-1:0]      o_tx_data,
    output logic                             o_tx_valid,
    input  wire logic                        i_tx_ready,
    input  wire logic                        i_suspended,
    input  wire logic                        i_wakeup_enabled,
    input  wire logic                        i_mode_sync_fifo,
    output logic                             o_resume_req,
    output logic                             o_send_now
);
    localparam int unsigned W = spfp_pkg::DATA_W;
    // ------------------------------------------------------------
    // interface clock: divided from i_mclk, port edges align to its rise
    // ------------------------------------------------------------
    logic       ifclk;        // interface clock level
    logic       if_edge;      // high in the mclk cycle that makes ifclk rise
    logic       mode_on;      // sync fifo mode active
    logic       tx_load;      // tx output word moves on this edge
    assign if_edge = !ifclk;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ifclk <= 1'b0;
        end else begin
            ifclk <= !ifclk;  // R2
        end
    end
    // ------------------------------------------------------------
    // receive buffer: usb core fills, partner drains
    // ------------------------------------------------------------
    logic [W-1:0] rxq_data;   // head byte
    logic [W-1:0] rxq_peek;   // byte behind the head
    logic [3:0]   rxq_cnt;    // bytes held, depth eight needs four bits
    logic [3:0]   next_rx_cnt; // occupancy after this edge
    logic         rxq_valid;  // head valid
    logic         rxq_pop;    // one byte consumed
    logic         rxq_in_rdy; // space for usb core
    logic         rx_push;    // core byte accepted
    spfp_fifo #(.WIDTH(W), .DEPTH(spfp_pkg::RX_DEPTH)) u_rxq (
        .i_mclk     (i_mclk),
        .i_reset    (i_reset),
        .i_wr_data  (i_rx_data),
        .i_wr_valid (rx_push),
        .o_wr_ready (rxq_in_rdy),
        .o_rd_data  (rxq_data),
        .o_rd_valid (rxq_valid),
        .o_peek_data(rxq_peek),
        .o_count    (rxq_cnt),
        .i_rd_ready (rxq_pop)
    );
    // ready is registered, so it already allows for this edge's push and pop;
    // a push the core thinks was taken is never dropped
    assign rx_push     = i_rx_valid && o_rx_ready && rxq_in_rdy;
    assign next_rx_cnt = rxq_cnt + 4'(rx_push) - 4'(rxq_pop);
    // the flag is registered at the edge and already counts a pop in that edge
    assign rxq_pop = if_edge && mode_on && !o_rx_data_avail_n && !i_rd_n;  // R5 R9 R15
    // ------------------------------------------------------------
    // transmit buffer: partner fills, usb core drains
    // ------------------------------------------------------------
    logic         txq_push;   // byte taken from bus
    logic         txq_in_rdy; // space available
    logic [W-1:0] txq_data;
    logic         txq_valid;
    logic [3:0]   txq_cnt;    // bytes held in the tx buffer
    spfp_fifo #(.WIDTH(W), .DEPTH(spfp_pkg::TX_DEPTH)) u_txq (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_wr_data (i_fifo_data_bus),
        .i_wr_valid(txq_push),
        .o_wr_ready(txq_in_rdy),
        .o_rd_data (txq_data),
        .o_rd_valid(txq_valid),
        .o_peek_data(),
        .o_count   (txq_cnt),
        .i_rd_ready(tx_load)
    );
    assign txq_push = if_edge && mode_on && !o_tx_space_avail_n && !i_wr_n;  // R8 R10 R15
    // ------------------------------------------------------------
    // mode gate: port only runs once sync fifo mode is selected
    // ------------------------------------------------------------
    // read and write strobes are ignored until the mode is selected; the wake strobe is not
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            mode_on <= 1'b0;
        end else begin
            mode_on <= i_mode_sync_fifo;  // R14
        end
    end
    // ------------------------------------------------------------
    // flags: updated on interface clock rise only
    // ------------------------------------------------------------
    logic rx_more;   // a byte remains after this edge's pop
    logic tx_room;   // room remains after this edge's push
    // conservative: a core push or pop in the same edge is seen one port edge later
    assign rx_more = rxq_pop ? (rxq_cnt > 4'h1) : rxq_valid;
    assign tx_room = txq_push ? (txq_cnt < 4'(spfp_pkg::TX_DEPTH - 1)) : txq_in_rdy;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rx_data_avail_n  <= spfp_pkg::RST_FLAG_N;
            o_tx_space_avail_n <= spfp_pkg::RST_FLAG_N;
        end else if (if_edge) begin
            o_rx_data_avail_n  <= !(mode_on && rx_more);   // R4 R1
            o_tx_space_avail_n <= !(mode_on && tx_room);   // R7 R1
        end
    end
    // ------------------------------------------------------------
    // data bus drive: head byte, advanced on each pop
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_fifo_data_bus    <= '0;
            o_fifo_data_bus_oe <= 1'b0;
        end else if (if_edge) begin
            o_fifo_data_bus_oe <= !i_oe_n;   // R3
            // after a pop show the next entry; otherwise keep the head
            if (rxq_pop) begin
                o_fifo_data_bus <= rxq_peek;  // R9
            end else begin
                o_fifo_data_bus <= rxq_data;  // R11
            end
        end
    end
    // ------------------------------------------------------------
    // tx output register toward usb core
    // ------------------------------------------------------------
    // the buffer pops exactly when the output word moves on; popping on a bare
    // ready would drop or repeat bytes while the core stalls
    assign tx_load = !o_tx_valid || i_tx_ready;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_tx_valid <= 1'b0;
            o_tx_data  <= '0;
        end else if (tx_load) begin
            o_tx_valid <= txq_valid;
            o_tx_data  <= txq_data;
        end
    end
    // ------------------------------------------------------------
    // send-now / wake strobe
    // ------------------------------------------------------------
    spfp_pkg::spfp_wake_t wk_state;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wk_state     <= spfp_pkg::SPFP_WK_IDLE;
            o_resume_req <= 1'b0;
            o_send_now   <= 1'b0;
        end else begin
            o_resume_req <= 1'b0;
            o_send_now   <= 1'b0;
            case (wk_state)
                spfp_pkg::SPFP_WK_IDLE: begin
                    if (!i_send_now_wakeup_n) begin
                        wk_state <= spfp_pkg::SPFP_WK_LOW;
                    end
                end
                spfp_pkg::SPFP_WK_LOW: begin
                    // act on release so a long strobe counts once
                    if (i_send_now_wakeup_n) begin
                        wk_state <= spfp_pkg::SPFP_WK_ACT;
                    end
                end
                spfp_pkg::SPFP_WK_ACT: begin
                    wk_state     <= spfp_pkg::SPFP_WK_IDLE;
                    o_resume_req <= i_suspended && i_wakeup_enabled;  // R12
                    o_send_now   <= !i_suspended;                     // R13
                end
                default: begin
                    wk_state <= spfp_pkg::SPFP_WK_IDLE;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // clock and power pins, and rx ready toward the usb core
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_interface_clock_out <= 1'b0;
            o_usb_active_n        <= 1'b1;
            o_rx_ready            <= 1'b0;
        end else begin
            o_interface_clock_out <= if_edge;  // equals ifclk, both change on the same edge
            o_usb_active_n        <= i_suspended;
            // room for one more byte after this edge's traffic
            o_rx_ready            <= (next_rx_cnt < 4'(spfp_pkg::RX_DEPTH));
        end
    end
endmodule // spfp_port

// ---- tb/spfp_port_chk.sv ----
// concurrent checks on the pins of the parallel fifo port
`timescale 1ns/1ps
module spfp_port_chk (
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic       o_interface_clock_out,
    input wire logic [7:0] o_fifo_data_bus,
    input wire logic       o_fifo_data_bus_oe,
    input wire logic       o_rx_data_avail_n,
    input wire logic       o_tx_space_avail_n,
    input wire logic       i_oe_n,
    input wire logic       i_send_now_wakeup_n,
    input wire logic       o_usb_active_n,
    input wire logic       i_suspended,
    input wire logic       i_wakeup_enabled,
    input wire logic       o_resume_req,
    input wire logic       o_send_now
);
    // ------------------------------------------------
    // everything is sampled on the core clock
    // ------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // strobe released after its low phase
    sequence s_release; $rose(i_send_now_wakeup_n); endsequence
    clk_toggle_a : assert property (
        !$past(i_reset) |-> o_interface_clock_out != $past(o_interface_clock_out))
        else $error("interface clock missed a toggle");
    reset_vals_a : assert property (disable iff (1'b0) $past(i_reset) |->
        o_rx_data_avail_n && o_tx_space_avail_n && !o_fifo_data_bus_oe && !o_resume_req)
        else $error("outputs not at reset values");
    bus_drive_a : assert property (
        o_fifo_data_bus_oe |-> !$past(i_oe_n) || !$past(i_oe_n, 2))
        else $error("bus driven without output enable");
    port_stand_a : assert property (o_interface_clock_out |=>
        $stable(o_rx_data_avail_n) && $stable(o_tx_space_avail_n) && $stable(o_fifo_data_bus))
        else $error("port outputs moved between port edges");
    usb_active_a : assert property (
        !$past(i_reset) |-> o_usb_active_n == $past(i_suspended))
        else $error("usb active flag does not follow suspend");
    pulse_once_a : assert property (
        o_resume_req || o_send_now |=> !o_resume_req && !o_send_now)
        else $error("action pulse longer than one cycle");
    wake_resume_a : assert property (
        s_release ##0 (i_suspended && i_wakeup_enabled) |-> ##[1:6] o_resume_req)
        else $error("no resume request after strobe");
    send_now_a : assert property (
        s_release ##0 !i_suspended |-> ##[1:6] o_send_now && !o_resume_req)
        else $error("no send-now pulse after strobe");
endmodule // spfp_port_chk
bind spfp_port spfp_port_chk u_chk (.i_mclk, .i_reset, .o_interface_clock_out,
    .o_fifo_data_bus, .o_fifo_data_bus_oe, .o_rx_data_avail_n, .o_tx_space_avail_n,
    .i_oe_n, .i_send_now_wakeup_n, .o_usb_active_n, .i_suspended, .i_wakeup_enabled,
    .o_resume_req, .o_send_now);

// ---- tb/spfp_ctl_model.sv ----
// controller model that masters the parallel fifo port
`timescale 1ns/1ps
module spfp_ctl_model (
    input  wire logic       i_mclk,
    input  wire logic       i_ifclk,     // device interface clock
    input  wire logic       i_rx_flag_n,
    input  wire logic       i_tx_flag_n,
    input  wire logic [7:0] i_bus,       // resolved bus level
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_oe_n,
    output logic            o_drv,       // high while we drive the bus
    output logic [7:0]      o_bus
);
    logic [7:0] rq[$];  // bytes read from the device
    initial {o_rd_n, o_wr_n, o_oe_n, o_drv, o_bus} = 12'he00;
    // read n bytes; slow lifts the strobe after every byte
    task automatic rd_bytes(input int n, input bit slow, output int k);
        k = 0;
        @(posedge i_mclk iff !i_ifclk) o_oe_n <= 1'b0;
        @(posedge i_mclk iff !i_ifclk) o_rd_n <= 1'b0;
        repeat (64) if (k < n) begin
            @(posedge i_mclk iff !i_ifclk);
            if (!o_rd_n && !i_rx_flag_n) begin
                rq.push_back(i_bus);
                k++;
                o_rd_n <= slow || k == n;
            end else begin
                o_rd_n <= 1'b0;  // paused or refused: strobe again
            end
        end
        @(posedge i_mclk iff !i_ifclk) o_rd_n <= 1'b1;
        o_oe_n <= 1'b1;
    endtask
    // write bytes; a stalled device keeps the strobe waiting for up to 64 port edges
    task automatic wr_bytes(input logic [7:0] d[$], input bit slow, output int k);
        bit acc;
        bit stop;
        k = 0;
        @(posedge i_mclk iff !i_ifclk) o_bus <= d[0];
        o_wr_n <= 1'b0;
        o_drv <= 1'b1;
        repeat (64) if (k < d.size()) begin
            @(posedge i_mclk iff !i_ifclk);
            acc = !o_wr_n && !i_tx_flag_n;
            k += int'(acc);
            stop = (k == d.size()) || (slow && acc);
            o_wr_n <= stop;
            o_drv <= !stop;
            if (k < d.size()) o_bus <= d[k];
        end
        @(posedge i_mclk iff !i_ifclk) o_wr_n <= 1'b1;
        o_drv <= 1'b0;
    endtask
endmodule // spfp_ctl_model

// ---- tb/tb_top.sv ----
// self-checking bench for the parallel fifo port
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    logic       i_mclk = 1'b0, i_reset = 1'b1, rx_v = 1'b0, tx_rdy = 1'b0;
    logic       susp = 1'b0, wk_en = 1'b0, send_now_wakeup_n_n = 1'b1, mode = 1'b1;
    logic       ifclk, oe, rx_n, tx_n, rd_n, wr_n, oe_n, drv, usb_n, rs, sn, rx_rdy, tx_v;
    logic [7:0] rx_d = 8'h00, dev_bus, ctl_bus, tx_d, bus_lvl;
    logic [7:0] txq[$], exp_q[$];  // core tx stream and expected bytes
    int         bad_count = 0, checked = 0, rs_cnt = 0, sn_cnt = 0;
    always #10 i_mclk = ~i_mclk;  // 50 MHz
    // a released bus shows the inverse of the controller's last value, never a kind zero
    assign bus_lvl = oe ? dev_bus : (drv ? ctl_bus : ~ctl_bus);
    spfp_port u_dut (.i_mclk, .i_reset, .o_interface_clock_out(ifclk), .i_fifo_data_bus(bus_lvl),
        .o_fifo_data_bus(dev_bus), .o_fifo_data_bus_oe(oe), .o_rx_data_avail_n(rx_n),
        .o_tx_space_avail_n(tx_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_oe_n(oe_n),
        .i_send_now_wakeup_n(send_now_wakeup_n_n), .o_usb_active_n(usb_n), .i_rx_data(rx_d),
        .i_rx_valid(rx_v), .o_rx_ready(rx_rdy), .o_tx_data(tx_d), .o_tx_valid(tx_v),
        .i_tx_ready(tx_rdy), .i_suspended(susp), .i_wakeup_enabled(wk_en),
        .i_mode_sync_fifo(mode), .o_resume_req(rs), .o_send_now(sn));
    spfp_ctl_model u_ctl (.i_mclk, .i_ifclk(ifclk), .i_rx_flag_n(rx_n), .i_tx_flag_n(tx_n),
        .i_bus(bus_lvl), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_drv(drv),
        .o_bus(ctl_bus));
    // core side monitor: tx bytes and action pulses
    always @(posedge i_mclk) begin
        if (tx_v && tx_rdy) txq.push_back(tx_d);
        rs_cnt += int'(rs === 1'b1);
        sn_cnt += int'(sn === 1'b1);
    end
    // one core push, held until ready is seen
    task automatic push_rx(input logic [7:0] d);
        int n = 0;
        @(posedge i_mclk) rx_d <= d;
        rx_v <= 1'b1;
        @(posedge i_mclk);
        while (rx_rdy !== 1'b1 && n++ < 50) @(posedge i_mclk);
        rx_v <= 1'b0;
    endtask
    // eight bytes read back to back, then the flag reads empty
    task automatic t_rx;
        int k;
        u_ctl.rq.delete();
        for (int i = 0; i < 8; i++) push_rx(8'h5a ^ 8'(i));
        @(negedge i_mclk);
        `CHK(rx_rdy, 1'b0)
        u_ctl.rd_bytes(8, 1'b0, k);
        @(negedge i_mclk);
        for (int i = 0; i < 8; i++) `CHK(u_ctl.rq[i], 8'h5a ^ 8'(i))
        `CHK(rx_n, 1'b1)
        $display("test rx done");
    endtask
    // strobe held low on an empty buffer must not move the read side
    task automatic t_refuse;
        int k;
        u_ctl.rq.delete();
        u_ctl.rd_bytes(1, 1'b0, k);
        `CHK(k, 0)
        push_rx(8'hc3);
        push_rx(8'h3c);
        u_ctl.rd_bytes(2, 1'b1, k);
        `CHK({u_ctl.rq[0], u_ctl.rq[1]}, 16'hc33c)
        $display("test refuse done");
    endtask
    // fill the tx buffer against a stalled core, then drain with slow writes
    task automatic t_tx;
        int k;
        int j;
        txq.delete();
        for (int i = 0; i < 12; i++) exp_q.push_back(8'h81 + 8'(i));
        u_ctl.wr_bytes(exp_q, 1'b0, k);
        @(negedge i_mclk);
        `CHK(k >= 8 && k < 12, 1'b1)
        `CHK(tx_n, 1'b1)
        @(posedge i_mclk) tx_rdy <= 1'b1;
        u_ctl.wr_bytes(exp_q[k:$], 1'b1, j);
        repeat (40) @(posedge i_mclk);
        `CHK(txq.size(), 12)
        for (int i = 0; i < 12; i++) `CHK(txq[i], exp_q[i])
        $display("test tx done");
    endtask
    // send-now strobe in each power state: suspend, wake enable, resume, send
    task automatic t_wake;
        logic [3:0] cases[3] = '{4'b1110, 4'b1000, 4'b0101};
        int r0;
        int s0;
        foreach (cases[i]) begin
            @(posedge i_mclk) susp <= cases[i][3];
            wk_en <= cases[i][2];
            repeat (8) @(posedge i_mclk);
            `CHK(usb_n, cases[i][3])
            r0 = rs_cnt;
            s0 = sn_cnt;
            @(posedge i_mclk iff !ifclk) send_now_wakeup_n_n <= 1'b0;
            repeat (2) @(posedge i_mclk iff !ifclk);
            send_now_wakeup_n_n <= 1'b1;
            repeat (12) @(posedge i_mclk);
            `CHK(rs_cnt - r0, int'(cases[i][1]))
            `CHK(sn_cnt - s0, int'(cases[i][0]))
        end
        $display("test wake done");
    endtask
    // port held off until the mode is selected, then the waiting byte reads out
    task automatic t_mode;
        int k;
        u_ctl.rq.delete();
        @(posedge i_mclk) mode <= 1'b0;
        push_rx(8'h96);
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK({rx_n, tx_n}, 2'b11)
        @(posedge i_mclk) mode <= 1'b1;
        u_ctl.rd_bytes(1, 1'b0, k);
        `CHK(k, 1)
        `CHK(u_ctl.rq[0], 8'h96)
        $display("test mode done");
    endtask
    task automatic summarize;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (11) @(posedge i_mclk);
        `CHK({rx_n, tx_n, oe}, 3'b110)
        @(posedge i_mclk) i_reset <= 1'b0;
        repeat (4) @(posedge i_mclk);
        t_rx;
        t_refuse;
        t_tx;
        t_mode;
        t_wake;
        summarize;
    end
    // all tests need well under a thousand cycles; this bound cuts a hang short
    initial begin
        repeat (20000) @(posedge i_mclk);
        bad_count++;
        summarize;
    end
endmodule // tb_top
